/* rtl/usart_pkg.sv */
// shared constants for the serial port baud, wake and register logic
package usart_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] RXCTL_OFS = 8'h04;
  localparam logic [7:0] PSR_OFS   = 8'h08;
  localparam logic [7:0] BAUD_OFS  = 8'h0C;
  localparam logic [7:0] TXD_OFS   = 8'h10;
  localparam logic [7:0] RXD_OFS   = 8'h14;
  localparam logic [7:0] PWR_OFS   = 8'h18;
  localparam logic [7:0] WAKE_OFS  = 8'h1C;
  // serial_control_reg fields
  localparam int CTL_LO    = 0;
  localparam int CTL_HI    = 1;
  localparam int CTL_TX9   = 2;
  localparam int CTL_SYNC  = 3;
  localparam int CTL_STOP2 = 4;
  localparam int CTL_S78   = 5;
  // rx_control_status_reg fields
  localparam int RXC_WAIT  = 0;
  // power register fields
  localparam int PWR_HALT  = 0;
  localparam int PWR_IDLE  = 1;
  localparam int PWR_XTAL  = 2;
  // wake register: enable byte low, edge byte high, serial pin on bit 3
  localparam int WAKE_SRC  = 3;
  localparam int WAKE_EDGE = 11;
  // values after reset
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] PSR_RST  = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // oversample ticks per bit
  localparam logic [4:0] OS_ASYNC      = 5'h10;
  localparam logic [4:0] OS_SYNC       = 5'h02;
  localparam logic [4:0] OS_STOP78     = 5'h0E;
  localparam logic [4:0] OS_ASYNC_HALF = 5'h08;
  localparam logic [4:0] OS_SYNC_HALF  = 5'h01;
  // oscillator settling after a wake from halt
  localparam logic [8:0] OSC_STAB_CYCLES = 9'h100;

  function automatic logic [3:0] data_bits(input logic lo, input logic hi);
    return hi ? 4'h9 : (lo ? 4'h7 : 4'h8);
  endfunction
endpackage

/* rtl/baud_gen.sv */
// baud chain: half-step prescaler followed by an 11-bit divisor counter
`timescale 1ns/10ps
`default_nettype none
module baud_gen
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [4:0]  presc_sel,
  input  wire logic [10:0] divisor,
  output logic             os_tick
);
  logic [4:0]  pre_cnt_q;
  logic        phase_q;
  logic [10:0] div_cnt_q;

  wire         run      = presc_sel != 5'h00;
  wire  [5:0]  span     = {1'b0, presc_sel} + 6'h01;
  wire  [4:0]  lo_len   = span[5:1];
  wire  [4:0]  hi_len   = 5'(span - {1'b0, lo_len});
  wire         pre_tick = run && pre_cnt_q == 5'h00;
  // odd spans alternate floor and ceiling counts
  wire  [4:0]  pre_rld  = (phase_q ? hi_len : lo_len) - 5'h01;
  wire  [4:0]  pre_cnt_d = !run ? 5'h00 : (pre_tick ? pre_rld : pre_cnt_q - 5'h01);
  wire  [10:0] div_cnt_d = !run ? 11'h000 :
                           !pre_tick ? div_cnt_q :
                           (div_cnt_q == 11'h000) ? divisor : div_cnt_q - 11'h001;

  assign os_tick = pre_tick && div_cnt_q == 11'h000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_cnt_q <= 5'h00;
      phase_q   <= 1'b0;
      div_cnt_q <= 11'h000;
    end
    else
    begin
      pre_cnt_q <= pre_cnt_d;
      phase_q   <= run && (pre_tick ? !phase_q : phase_q);
      div_cnt_q <= div_cnt_d;
    end
  end

  // a stopped chain restarts from cleared counters, so the first tick is immediate
  AST_STOP_NO_TICK: assert property (@(posedge hclk) disable iff (!hresetn)
    !run |=> run || (!os_tick && pre_cnt_q == 5'h00 && div_cnt_q == 11'h000 && !phase_q))
    else $error("baud tick while prescaler stopped");
  AST_DIV_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (os_tick ##1 run) |-> div_cnt_q == $past(divisor)) else $error("divisor not reloaded");
  AST_HALF_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (pre_tick && presc_sel == 5'h02 ##1 presc_sel == 5'h02 && !pre_tick)
    |=> pre_tick || presc_sel != 5'h02) else $error("factor 1.5 spacing wrong");
endmodule // baud_gen
`default_nettype wire

/* rtl/wake_ctrl.sv */
// low-power state, wake on serial line edge and oscillator settling hold
`timescale 1ns/10ps
`default_nettype none
module wake_ctrl
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enter_halt,
  input  wire logic enter_idle,
  input  wire logic xtal_osc,
  input  wire logic wake_en,
  input  wire logic wake_fall,
  input  wire logic line_level,
  output logic      low_power,
  output logic      exec_hold
);
  logic       lowp_q;
  logic       halt_q;
  logic       line_prev_q;
  logic       exec_hold_q;
  logic [8:0] stab_q;

  wire       edge_ok    = wake_fall ? (line_prev_q && !line_level) : (!line_prev_q && line_level);
  wire       wake_evt   = lowp_q && wake_en && edge_ok;
  wire       stab_start = wake_evt && halt_q && xtal_osc;
  wire       lowp_d     = (enter_halt || enter_idle) ? 1'b1 : (wake_evt ? 1'b0 : lowp_q);
  wire [8:0] stab_d     = stab_start ? usart_pkg::OSC_STAB_CYCLES :
                          (stab_q != 9'h000 ? stab_q - 9'h001 : 9'h000);

  assign low_power = lowp_q;
  assign exec_hold = exec_hold_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lowp_q      <= 1'b0;
      halt_q      <= 1'b0;
      line_prev_q <= 1'b1;
      exec_hold_q <= 1'b0;
      stab_q      <= 9'h000;
    end
    else
    begin
      lowp_q      <= lowp_d;
      halt_q      <= enter_halt ? 1'b1 : (enter_idle ? 1'b0 : halt_q);
      line_prev_q <= line_level;
      stab_q      <= stab_d;
      exec_hold_q <= lowp_d || stab_d != 9'h000;
    end
  end

  AST_WAKE_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_evt |=> !low_power) else $error("no exit on wake edge");
  AST_OSC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    stab_start |-> ##256 exec_hold ##1 !exec_hold) else $error("settling hold not 256");
  COV_XTAL_WAKE: cover property (@(posedge hclk) disable iff (!hresetn) stab_start);
endmodule // wake_ctrl
`default_nettype wire

/* rtl/usart_baud_wake_attention.sv */
// serial port core: AHB-Lite registers, framing, loopback, attention and wake
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module usart_baud_wake_attention
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             low_power,
  output logic             exec_hold
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } frame_state_e;

  frame_state_e tx_state_q;
  frame_state_e rx_state_q;
  logic        pend_q;
  logic        a_wr_q;
  logic        a_hit_q;
  logic [7:0]  a_addr_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic [5:0]  serial_control_reg_q;
  logic        tx_buffer_empty_flag_q;
  logic        xmtg_q;
  logic        address_wait_bit_q;
  logic        rx_ninth_bit_q;
  logic        ferr_q;
  logic        oerr_q;
  logic        rx_full_flag_q;
  logic [7:0]  prescale_select_reg_q;
  logic [7:0]  baud_lo_q;
  logic [7:0]  tx_holding_reg_q;
  logic [7:0]  rx_holding_reg_q;
  logic        xtal_q;
  logic [7:0]  wake_enable_reg_q;
  logic [7:0]  wake_edge_reg_q;
  logic        rx_meta_q;
  logic        rx_sync_q;
  logic [8:0]  tx_shift_reg_q;
  logic        serial_out_q;
  logic [4:0]  tx_tick_q;
  logic [3:0]  tx_bit_q;
  logic [8:0]  rx_shift_reg_q;
  logic [4:0]  rx_tick_q;
  logic [3:0]  rx_bit_q;
  logic        os_tick;
  logic        lowp;

  // bus decode
  wire accept  = hsel && hready && htrans[1] && hsize == 3'b010;
  wire wr_en   = pend_q && a_wr_q && a_hit_q;
  wire wr_ctrl = wr_en && a_addr_q == usart_pkg::CTRL_OFS;
  wire wr_rxc  = wr_en && a_addr_q == usart_pkg::RXCTL_OFS;
  wire wr_psr  = wr_en && a_addr_q == usart_pkg::PSR_OFS;
  wire wr_baud = wr_en && a_addr_q == usart_pkg::BAUD_OFS;
  wire wr_txd  = wr_en && a_addr_q == usart_pkg::TXD_OFS;
  wire wr_pwr  = wr_en && a_addr_q == usart_pkg::PWR_OFS;
  wire wr_wake = wr_en && a_addr_q == usart_pkg::WAKE_OFS;
  wire rd_rxd  = pend_q && !a_wr_q && a_hit_q && a_addr_q == usart_pkg::RXD_OFS;
  wire go_halt = wr_pwr && hwdata[usart_pkg::PWR_HALT] && !lowp;
  wire go_idle = wr_pwr && hwdata[usart_pkg::PWR_IDLE] && !lowp && !go_halt;
  wire lp_enter = go_halt || go_idle;

  // frame geometry
  wire       lo_sel   = serial_control_reg_q[usart_pkg::CTL_LO];
  wire       hi_sel   = serial_control_reg_q[usart_pkg::CTL_HI];
  wire       sync_md  = serial_control_reg_q[usart_pkg::CTL_SYNC];
  wire       loopback = lo_sel && hi_sel;
  wire [3:0] nbits    = usart_pkg::data_bits(lo_sel, hi_sel);
  wire [4:0] bit_len  = sync_md ? usart_pkg::OS_SYNC : usart_pkg::OS_ASYNC;
  wire [4:0] half_len = sync_md ? usart_pkg::OS_SYNC_HALF : usart_pkg::OS_ASYNC_HALF;
  wire [10:0] divisor = {prescale_select_reg_q[2:0], baud_lo_q};

  // transmitter timing
  wire tx_last  = !serial_control_reg_q[usart_pkg::CTL_STOP2] || tx_bit_q[0];
  wire tx_short = tx_state_q == ST_STOP && tx_last && !sync_md
                  && serial_control_reg_q[usart_pkg::CTL_S78];
  wire [4:0] tx_len = tx_short ? usart_pkg::OS_STOP78 : bit_len;
  wire tx_end  = os_tick && tx_tick_q == tx_len - 5'h01;
  wire tx_load = os_tick && tx_state_q == ST_IDLE && !tx_buffer_empty_flag_q;
  wire tx_more = tx_state_q == ST_START || (tx_state_q == ST_DATA && tx_bit_q < nbits);

  // receiver timing
  wire rx_line = loopback ? serial_out_q : rx_sync_q;
  wire [4:0] rx_len = rx_state_q == ST_START ? half_len : bit_len;
  wire rx_end  = os_tick && rx_tick_q == rx_len - 5'h01;
  wire rx_done = rx_end && rx_state_q == ST_STOP;
  wire rx_keep = !address_wait_bit_q || rx_shift_reg_q[8];
  wire rx_take = rx_done && rx_keep;

  wire [7:0] rd_byte =
    !a_hit_q ? 8'h00 :
    a_addr_q == usart_pkg::CTRL_OFS ? {tx_buffer_empty_flag_q, xmtg_q, serial_control_reg_q} :
    a_addr_q == usart_pkg::RXCTL_OFS ? {3'h0, rx_full_flag_q, oerr_q, ferr_q,
                                        rx_ninth_bit_q, address_wait_bit_q} :
    a_addr_q == usart_pkg::PSR_OFS  ? prescale_select_reg_q :
    a_addr_q == usart_pkg::BAUD_OFS ? baud_lo_q :
    a_addr_q == usart_pkg::TXD_OFS  ? tx_holding_reg_q :
    a_addr_q == usart_pkg::RXD_OFS  ? rx_holding_reg_q :
    a_addr_q == usart_pkg::PWR_OFS  ? {3'h0, exec_hold, lowp, xtal_q, 2'h0} : 8'h00;
  wire [31:0] wake_word = {16'h0000, wake_edge_reg_q, wake_enable_reg_q};
  wire [31:0] rd_word = (a_hit_q && a_addr_q == usart_pkg::WAKE_OFS) ? wake_word
                                                                   : {24'h000000, rd_byte};

  assign hreadyout      = hreadyout_q;
  assign hrdata         = hrdata_q;
  assign hresp          = 1'b0;
  assign serial_out_pin = serial_out_q;
  assign low_power      = lowp;

  baud_gen u_baud
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .presc_sel (lowp ? 5'h00 : prescale_select_reg_q[7:3]),
    .divisor   (divisor),
    .os_tick   (os_tick)
  );

  wake_ctrl u_wake
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .enter_halt (go_halt),
    .enter_idle (go_idle),
    .xtal_osc   (xtal_q),
    .wake_en    (wake_enable_reg_q[usart_pkg::WAKE_SRC]),
    .wake_fall  (wake_edge_reg_q[usart_pkg::WAKE_SRC]),
    .line_level (rx_sync_q),
    .low_power  (lowp),
    .exec_hold  (exec_hold)
  );

  // bus slave: one wait state on every accepted word transfer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q      <= 1'b0;
      a_wr_q      <= 1'b0;
      a_hit_q     <= 1'b0;
      a_addr_q    <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h00000000;
    end
    else
    begin
      pend_q      <= accept;
      hreadyout_q <= !accept;
      if (accept)
      begin
        a_wr_q   <= hwrite;
        a_hit_q  <= haddr[31:5] == 27'h0000000 && haddr[1:0] == 2'h0;
        a_addr_q <= haddr[7:0];
      end
      if (pend_q && !a_wr_q)
        hrdata_q <= rd_word;
    end
  end

  // software-written registers and input synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_control_reg_q  <= usart_pkg::CTRL_RST;
      prescale_select_reg_q <= usart_pkg::PSR_RST;
      baud_lo_q             <= usart_pkg::BYTE_RST;
      tx_holding_reg_q      <= usart_pkg::BYTE_RST;
      xtal_q                <= 1'b0;
      wake_enable_reg_q     <= usart_pkg::BYTE_RST;
      wake_edge_reg_q       <= usart_pkg::BYTE_RST;
      rx_meta_q             <= 1'b1;
      rx_sync_q             <= 1'b1;
    end
    else
    begin
      rx_meta_q <= serial_in_pin;
      rx_sync_q <= rx_meta_q;
      if (wr_ctrl)
        serial_control_reg_q <= hwdata[5:0];
      if (wr_psr)
        prescale_select_reg_q <= hwdata[7:0];
      if (wr_baud)
        baud_lo_q <= hwdata[7:0];
      if (wr_txd)
        tx_holding_reg_q <= hwdata[7:0];
      if (wr_pwr)
        xtal_q <= hwdata[usart_pkg::PWR_XTAL];
      if (wr_wake)
      begin
        wake_enable_reg_q <= hwdata[7:0];
        wake_edge_reg_q   <= hwdata[15:8];
      end
    end
  end

  // status flags; hardware set beats software clear, except a TXD write beats a load on the empty flag and low-power entry beats both
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_buffer_empty_flag_q <= 1'b1;
      xmtg_q                 <= 1'b0;
      address_wait_bit_q     <= 1'b0;
      rx_ninth_bit_q         <= 1'b0;
      ferr_q                 <= 1'b0;
      oerr_q                 <= 1'b0;
      rx_full_flag_q         <= 1'b0;
      rx_holding_reg_q       <= 8'h00;
    end
    else
    begin
      // pending write keeps the buffer full even if a load happens together
      tx_buffer_empty_flag_q <= lp_enter || (!wr_txd && (tx_load || tx_buffer_empty_flag_q));
      xmtg_q <= !lp_enter && (tx_load || (xmtg_q && !(tx_end && tx_state_q == ST_STOP
                && tx_last && tx_buffer_empty_flag_q)));
      rx_full_flag_q <= !lp_enter && (rx_take || (rx_full_flag_q && !rd_rxd));
      ferr_q <= !lp_enter && ((rx_done && !rx_line) || (ferr_q && !wr_rxc));
      oerr_q <= !lp_enter && ((rx_take && rx_full_flag_q) || (oerr_q && !wr_rxc));
      rx_ninth_bit_q <= !lp_enter && (rx_take ? rx_shift_reg_q[8] : rx_ninth_bit_q);
      if (rx_take && address_wait_bit_q)
        address_wait_bit_q <= 1'b0;
      else if (wr_rxc)
        address_wait_bit_q <= hwdata[usart_pkg::RXC_WAIT];
      // a character finishing as low power is entered must not disturb the holding reg
      if (rx_take && !lp_enter)
        rx_holding_reg_q <= rx_shift_reg_q[7:0];
    end
  end

  // transmitter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_state_q     <= ST_IDLE;
      tx_shift_reg_q <= 9'h1FF;
      serial_out_q   <= 1'b1;
      tx_tick_q      <= 5'h00;
      tx_bit_q       <= 4'h0;
    end
    else if (lp_enter)
    begin
      tx_state_q     <= ST_IDLE;
      tx_shift_reg_q <= 9'h1FF;
      serial_out_q   <= 1'b1;
      tx_tick_q      <= 5'h00;
    end
    else if (tx_load)
    begin
      tx_shift_reg_q <= {serial_control_reg_q[usart_pkg::CTL_TX9], tx_holding_reg_q};
      serial_out_q   <= 1'b0;
      tx_state_q     <= ST_START;
      tx_tick_q      <= 5'h00;
      tx_bit_q       <= 4'h0;
    end
    else if (os_tick && tx_state_q != ST_IDLE)
    begin
      tx_tick_q <= tx_end ? 5'h00 : tx_tick_q + 5'h01;
      if (tx_end && tx_more)
      begin
        serial_out_q   <= tx_shift_reg_q[0];
        tx_shift_reg_q <= {1'b1, tx_shift_reg_q[8:1]};
        tx_bit_q       <= tx_bit_q + 4'h1;
        tx_state_q     <= ST_DATA;
      end
      else if (tx_end && tx_state_q == ST_DATA)
      begin
        serial_out_q <= 1'b1;
        tx_bit_q     <= 4'h0;
        tx_state_q   <= ST_STOP;
      end
      else if (tx_end)
      begin
        tx_bit_q   <= 4'h1;
        tx_state_q <= tx_last ? ST_IDLE : ST_STOP;
      end
    end
  end

  // receiver
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_q     <= ST_IDLE;
      rx_shift_reg_q <= 9'h000;
      rx_tick_q      <= 5'h00;
      rx_bit_q       <= 4'h0;
    end
    else if (lp_enter)
    begin
      rx_state_q <= ST_IDLE;
      rx_tick_q  <= 5'h00;
    end
    else if (os_tick)
    begin
      rx_tick_q <= rx_end ? 5'h00 : rx_tick_q + 5'h01;
      unique case (rx_state_q)
        ST_IDLE:
        begin
          rx_tick_q  <= 5'h00;
          rx_state_q <= rx_line ? ST_IDLE : ST_START;
        end
        ST_START:
          if (rx_end)
          begin
            rx_state_q     <= rx_line ? ST_IDLE : ST_DATA;
            rx_shift_reg_q <= 9'h000;
            rx_bit_q       <= 4'h0;
          end
        ST_DATA:
          if (rx_end)
          begin
            rx_shift_reg_q[rx_bit_q] <= rx_line;
            rx_bit_q                 <= rx_bit_q + 4'h1;
            rx_state_q <= (rx_bit_q == nbits - 4'h1) ? ST_STOP : ST_DATA;
          end
        ST_STOP:
          if (rx_end)
            rx_state_q <= ST_IDLE;
      endcase
    end
  end

  AST_ADDR_DISCARD: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && address_wait_bit_q && !rx_shift_reg_q[8] && !rd_rxd && !lp_enter)
    |=> $stable(rx_holding_reg_q) && $stable(rx_full_flag_q) && address_wait_bit_q)
    else $error("data character passed in address wait");
  AST_ADDR_ACCEPT: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && address_wait_bit_q && rx_shift_reg_q[8] && !lp_enter)
    |=> rx_full_flag_q && !address_wait_bit_q && rx_ninth_bit_q)
    else $error("address character not accepted");
  AST_REINIT: assert property (@(posedge hclk) disable iff (!hresetn)
    lp_enter |=> tx_buffer_empty_flag_q && !rx_full_flag_q && !ferr_q && !oerr_q && !xmtg_q
    && tx_shift_reg_q == 9'h1FF && $stable(rx_holding_reg_q)) else $error("reinit incomplete");
  AST_LOOPBACK: assert property (@(posedge hclk) disable iff (!hresetn)
    (loopback && rx_state_q == ST_DATA && rx_end && !lp_enter)
    |=> rx_shift_reg_q[$past(rx_bit_q)] == $past(serial_out_q))
    else $error("loopback sample not from tx output");
  AST_ERR_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_rxc && !rx_done) |=> !ferr_q && !oerr_q) else $error("error flags survive write");
  AST_TX_NINTH: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_load && !lp_enter) |=> tx_shift_reg_q[8] == $past(serial_control_reg_q[2])
    && !serial_out_q) else $error("ninth tx bit not from control");
  COV_LOOP_FRAME: cover property (@(posedge hclk) disable iff (!hresetn) loopback && rx_take);
  COV_ADDR_HIT: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_take && address_wait_bit_q);
  COV_LP_ENTER: cover property (@(posedge hclk) disable iff (!hresetn) lp_enter);
endmodule // usart_baud_wake_attention
`default_nettype wire

/* tb/remote_node.sv */
// remote serial node driving the receive line
`timescale 1ns/10ps
`default_nettype none
module remote_node
(
  input  wire logic hclk,
  output logic      line
);
  initial line = 1'b1;
  // start bit, nine bits lsb first, one stop bit, then idle high
  task automatic send(input logic [8:0] d, input int bc);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line <= f[i];
      repeat (bc) @(posedge hclk);
    end
  endtask
endmodule // remote_node
`default_nettype wire

/* tb/usart_baud_wake_attention_test.sv */
// self-checking bench for the serial port core
`timescale 1ns/10ps
`default_nettype none
module usart_baud_wake_attention_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        hreadyout, hresp, rx_line, tx_line, low_power, exec_hold;
  logic        rd_pend = 1'b0;
  logic [7:0]  seed = 8'h28;
  logic [31:0] rd_q[$];
  int          bw_q[$];
  int          lo_n = 0, fail_count = 0, tests_run = 0;
  // prescale code, divisor-1, sync, expected start bit cycles
  int          cfg[7][4] = '{'{1,0,0,16}, '{2,0,0,24}, '{3,1,0,64}, '{1,2,0,48},
                             '{1,1,1,4}, '{1,5,0,96}, '{1,11,0,192}};

  usart_baud_wake_attention uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .serial_in_pin(rx_line),
    .serial_out_pin(tx_line), .low_power(low_power), .exec_hold(exec_hold)
  );
  remote_node node (.hclk(hclk), .line(rx_line));

  always #2 hclk = ~hclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (e !== s)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic finish_test;
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read data and start bit width monitor
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      chk("hrdata", rd_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (tx_line === 1'b0)
      lo_n++;
    else if (lo_n > 0)
    begin
      if (bw_q.size() > 0)
        chk("start_width", bw_q.pop_front(), lo_n);
      lo_n = 0;
    end
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    finish_test;
  end

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(usart_pkg::CTRL_OFS, 32'h80);
    rd(usart_pkg::PSR_OFS, 32'h0);
    rd(8'h40, 32'h0);
    seed = lfsr(seed);
    wr(usart_pkg::BAUD_OFS, {24'h0, seed});
    rd(usart_pkg::BAUD_OFS, {24'h0, seed});
    // rate is programmed while the baud clock is stopped, then started
    for (int i = 0; i < 7; i++)
    begin
      wr(usart_pkg::PSR_OFS, 32'h0);
      wr(usart_pkg::BAUD_OFS, cfg[i][1]);
      wr(usart_pkg::CTRL_OFS, cfg[i][2] << usart_pkg::CTL_SYNC);
      wr(usart_pkg::PSR_OFS, cfg[i][0] << 3);
      bw_q.push_back(cfg[i][3]);
      wr(usart_pkg::TXD_OFS, 32'hFF);
      repeat (12 * cfg[i][3]) @(posedge hclk);
    end
    wr(usart_pkg::PSR_OFS, 32'h0);
    wr(usart_pkg::BAUD_OFS, 32'h0);
    wr(usart_pkg::CTRL_OFS, 32'h2);
    wr(usart_pkg::PSR_OFS, 32'h8);
    wr(usart_pkg::RXCTL_OFS, 32'h1);
    node.send(9'h0A5, 16);
    rd(usart_pkg::RXCTL_OFS, 32'h1);
    node.send(9'h15A, 16);
    rd(usart_pkg::RXCTL_OFS, 32'h12);
    rd(usart_pkg::RXD_OFS, 32'h5A);
    wr(usart_pkg::CTRL_OFS, 32'h7);
    wr(usart_pkg::TXD_OFS, 32'h3C);
    repeat (250) @(posedge hclk);
    rd(usart_pkg::RXCTL_OFS, 32'h12);
    rd(usart_pkg::RXD_OFS, 32'h3C);
    wr(usart_pkg::WAKE_OFS, 32'h808);
    wr(usart_pkg::PWR_OFS, 32'h5);
    rd(usart_pkg::CTRL_OFS, 32'h87);
    rd(usart_pkg::RXCTL_OFS, 32'h0);
    rd(usart_pkg::PWR_OFS, 32'h1C);
    chk("tx_line", 32'h1, {31'h0, tx_line});
    node.send(9'h1FF, 16);
    chk("low_power", 32'h0, {31'h0, low_power});
    repeat (40) @(posedge hclk);
    chk("exec_hold", 32'h1, {31'h0, exec_hold});
    repeat (60) @(posedge hclk);
    chk("exec_hold", 32'h0, {31'h0, exec_hold});
    finish_test;
  end
endmodule // usart_baud_wake_attention_test
`default_nettype wire
